//--- icapp_map.vh
// register map, field positions, reset values and codes for the image chunk appender
`ifndef ICAPP_MAP_VH
`define ICAPP_MAP_VH

// =====================================================================
// register byte offsets
`define ICAPP_OFF_CTRL 8'h00
`define ICAPP_OFF_SEL 8'h04
`define ICAPP_OFF_EN 8'h08
`define ICAPP_OFF_LINES 8'h0c
`define ICAPP_OFF_CRC 8'h10
`define ICAPP_OFF_STAT 8'h14

// =====================================================================
// field positions
`define ICAPP_CTRL_MODE 0
`define ICAPP_CTRL_SEQ 1
`define ICAPP_EN_BIT 0
`define ICAPP_STAT_BUSY 4

// =====================================================================
// chunk selector codes, also the bit index in the enable vector
`define ICAPP_SEL_LINES 2'h0
`define ICAPP_SEL_CRC 2'h1
`define ICAPP_SEL_SEQ 2'h2
`define ICAPP_NCHUNK 3

// =====================================================================
// reset values
`define ICAPP_RST_MODE 1'h0
`define ICAPP_RST_SEL 2'h0
`define ICAPP_RST_EN 3'h0
`define ICAPP_RST_CRC 16'h0000

// =====================================================================
// checksum and line defaults
`define ICAPP_CRC_POLY 16'h1021
`define ICAPP_N_IN 1
`define ICAPP_N_OUT 4
`define ICAPP_SEQ_W 8
`define ICAPP_SNAP_W 32

`endif

//--- icapp_sync2.v
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module icapp_sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// levels
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_r;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // icapp_sync2

//--- icapp_crc16.v
// one byte step of the 16-bit checksum, msb first, no reflection
`timescale 1ns/1ps
`include "icapp_map.vh"
module icapp_crc16 (
	// running value and byte
	input wire [15:0] crc_in,
	input wire [7:0] data,
	// updated value
	output reg [15:0] crc_out
);
	integer i;
	reg [15:0] c;

	always @* begin
		c = crc_in ^ {data, 8'h00};
		for (i = 0; i < 8; i = i + 1) begin
			if (c[15])
				c = {c[14:0], 1'b0} ^ `ICAPP_CRC_POLY;
			else
				c = {c[14:0], 1'b0};
		end
		crc_out = c;
	end
endmodule // icapp_crc16

//--- icapp_top.v
// image chunk appender: line snapshot, set index and checksum chunks behind apb
//
// Function
// - each acquisition trigger captures all input and output line levels for a chunk on that image.
// - the line snapshot chunk is one 32-bit word with fixed bits per line.
// - a snapshot bit is 0 for a low line and 1 for a high line at the trigger.
// - no chunk type can be enabled while global chunk mode is off.
// - clearing global chunk mode disables every chunk type.
// - a selector picks the chunk type and its enable makes it appear on every image.
// - with the checksum chunk enabled an xmodem crc is appended to each image.
// - the crc covers all image bytes and all chunks except its own two bytes.
// - the checksum chunk always comes last.
// - the set index chunk carries the parameter set in use when the frame was taken.
// - the set index chunk can be enabled only while sequencing is enabled.
`timescale 1ns/1ps
`include "icapp_map.vh"
module icapp_top #(
	parameter N_IN = `ICAPP_N_IN,
	parameter N_OUT = `ICAPP_N_OUT,
	parameter SEQ_W = `ICAPP_SEQ_W
) (
	// clock and reset
	input wire REF_CLK,
	input wire RSTN,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// pins sampled at trigger
	input wire TRIG,
	input wire [N_IN-1:0] IN_LINES,
	input wire [N_OUT-1:0] OUT_LINES,
	// sequencer state, same clock
	input wire SEQ_ACTIVE,
	input wire [SEQ_W-1:0] SEQ_INDEX,
	// image byte stream in
	input wire IMG_VALID,
	input wire [7:0] IMG_DATA,
	input wire IMG_LAST,
	output reg IMG_READY,
	// payload byte stream out
	output reg OUT_VALID,
	output reg [7:0] OUT_DATA,
	output reg OUT_LAST,
	input wire OUT_READY
);
	localparam NL = N_IN + N_OUT;
	localparam [1:0] S_PASS = 2'h0;
	localparam [1:0] S_LINE = 2'h1;
	localparam [1:0] S_SEQ = 2'h2;
	localparam [1:0] S_CRC = 2'h3;

	// =====================================================================
	// pin synchronisation and trigger edge
	wire [NL:0] pins_s;
	reg trig_d_r;
	wire trig_pulse;

	icapp_sync2 #(
		.WIDTH(NL + 1)
	) u_sync (
		.clk(REF_CLK),
		.rst_n(RSTN),
		.d({TRIG, OUT_LINES, IN_LINES}),
		.q(pins_s)
	);

	// pin rise reaches the logic two edges late
	assign trig_pulse = pins_s[NL] & ~trig_d_r;

	// =====================================================================
	// control state
	reg mode_r;
	reg [1:0] sel_r;
	reg [`ICAPP_NCHUNK-1:0] en_r;
	reg [`ICAPP_NCHUNK-1:0] fen_r;
	reg [`ICAPP_SNAP_W-1:0] snap_r;
	reg [SEQ_W-1:0] seqidx_r;
	reg [15:0] last_crc_r;
	reg [15:0] last_crc_nxt;

	// stream state
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [1:0] idx_r;
	reg [1:0] idx_nxt;
	reg [15:0] crc_r;
	reg [15:0] crc_nxt;
	reg ov_nxt;
	reg [7:0] od_nxt;
	reg ol_nxt;
	reg ready_nxt;
	reg load;
	reg [7:0] byte_sel;
	reg [1:0] follow;
	wire [15:0] crc_calc;

	// =====================================================================
	// apb decode
	wire apb_acc = PSEL & PENABLE & PREADY;
	wire apb_wr = apb_acc & PWRITE;
	wire addr_ok = (PADDR == `ICAPP_OFF_CTRL) || (PADDR == `ICAPP_OFF_SEL) ||
		(PADDR == `ICAPP_OFF_EN) || (PADDR == `ICAPP_OFF_LINES) ||
		(PADDR == `ICAPP_OFF_CRC) || (PADDR == `ICAPP_OFF_STAT);
	wire sel_ok = (sel_r == `ICAPP_SEL_LINES) || (sel_r == `ICAPP_SEL_CRC) || (sel_r == `ICAPP_SEL_SEQ);
	wire en_allow = mode_r && sel_ok && ((sel_r != `ICAPP_SEL_SEQ) || SEQ_ACTIVE);
	reg [31:0] rd_val;

	always @* begin
		rd_val = 32'h00000000;
		case (PADDR)
			`ICAPP_OFF_CTRL: begin
				rd_val[`ICAPP_CTRL_MODE] = mode_r;
				rd_val[`ICAPP_CTRL_SEQ] = SEQ_ACTIVE;
			end
			`ICAPP_OFF_SEL: rd_val[1:0] = sel_r;
			`ICAPP_OFF_EN: rd_val[`ICAPP_EN_BIT] = sel_ok ? en_r[sel_r] : 1'b0;
			`ICAPP_OFF_LINES: rd_val = snap_r;
			`ICAPP_OFF_CRC: rd_val[15:0] = last_crc_r;
			`ICAPP_OFF_STAT: begin
				rd_val[`ICAPP_NCHUNK-1:0] = en_r;
				rd_val[`ICAPP_STAT_BUSY] = (state_r != S_PASS);
			end
			default: rd_val = 32'h00000000;
		endcase
	end

	// one wait state per access
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_ok;
			if (PSEL & PENABLE & ~PREADY & ~PWRITE)
				PRDATA <= rd_val;
			else if (!PSEL)
				PRDATA <= 32'h00000000;
		end
	end

	// =====================================================================
	// control registers
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_r <= `ICAPP_RST_MODE;
			sel_r <= `ICAPP_RST_SEL;
			en_r <= `ICAPP_RST_EN;
		end else if (apb_wr) begin
			case (PADDR)
				`ICAPP_OFF_CTRL: begin
					mode_r <= PWDATA[`ICAPP_CTRL_MODE];
					if (!PWDATA[`ICAPP_CTRL_MODE])
						en_r <= {`ICAPP_NCHUNK{1'b0}};
				end
				`ICAPP_OFF_SEL: sel_r <= PWDATA[1:0];
				// a refused enable is dropped without an error
				`ICAPP_OFF_EN: begin
					if (!PWDATA[`ICAPP_EN_BIT] && sel_ok)
						en_r[sel_r] <= 1'b0;
					else if (en_allow)
						en_r[sel_r] <= 1'b1;
				end
				default: mode_r <= mode_r;
			endcase
		end
	end

	// =====================================================================
	// trigger capture of lines, set index and frame enables
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			trig_d_r <= 1'b0;
			snap_r <= {`ICAPP_SNAP_W{1'b0}};
			seqidx_r <= {SEQ_W{1'b0}};
			fen_r <= `ICAPP_RST_EN;
		end else begin
			trig_d_r <= pins_s[NL];
			// enables freeze per frame, later writes wait for the next trigger
			if (trig_pulse) begin
				snap_r <= {{(`ICAPP_SNAP_W - NL){1'b0}}, pins_s[NL-1:0]};
				seqidx_r <= SEQ_INDEX;
				fen_r <= en_r;
			end
		end
	end

	// =====================================================================
	// chunk sequencing
	// chunk order: lines, set index, checksum last
	wire [1:0] after_seq = fen_r[`ICAPP_SEL_CRC] ? S_CRC : S_PASS;
	wire [1:0] after_line = fen_r[`ICAPP_SEL_SEQ] ? S_SEQ : after_seq;
	wire [1:0] first_chunk = fen_r[`ICAPP_SEL_LINES] ? S_LINE : after_line;
	wire [31:0] seq_word = {{(32 - SEQ_W){1'b0}}, seqidx_r};

	function [7:0] word_byte;
		input [31:0] w;
		input [1:0] i;
		begin
			case (i)
				2'h0: word_byte = w[31:24];
				2'h1: word_byte = w[23:16];
				2'h2: word_byte = w[15:8];
				default: word_byte = w[7:0];
			endcase
		end
	endfunction

	icapp_crc16 u_crc (
		.crc_in(crc_r),
		.data(byte_sel),
		.crc_out(crc_calc)
	);

	always @* begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		crc_nxt = crc_r;
		last_crc_nxt = last_crc_r;
		ov_nxt = OUT_VALID;
		od_nxt = OUT_DATA;
		ol_nxt = OUT_LAST;
		load = 1'b0;
		byte_sel = 8'h00;
		follow = S_PASS;
		if (OUT_VALID && OUT_READY)
			ov_nxt = 1'b0;
		case (state_r)
			S_PASS: begin
				byte_sel = IMG_DATA;
				follow = IMG_LAST ? first_chunk : S_PASS;
				load = IMG_VALID & IMG_READY;
			end
			S_LINE: begin
				byte_sel = word_byte(snap_r, idx_r);
				follow = (idx_r == 2'h3) ? after_line : S_LINE;
				load = ~OUT_VALID;
			end
			S_SEQ: begin
				byte_sel = word_byte(seq_word, idx_r);
				follow = (idx_r == 2'h3) ? after_seq : S_SEQ;
				load = ~OUT_VALID;
			end
			S_CRC: begin
				byte_sel = (idx_r == 2'h0) ? crc_r[15:8] : crc_r[7:0];
				follow = (idx_r == 2'h1) ? S_PASS : S_CRC;
				load = ~OUT_VALID;
			end
			default: state_nxt = S_PASS;
		endcase
		if (load) begin
			ov_nxt = 1'b1;
			od_nxt = byte_sel;
			ol_nxt = (follow == S_PASS) && ((state_r != S_PASS) || IMG_LAST);
			state_nxt = follow;
			idx_nxt = ((follow != state_r) || (state_r == S_PASS)) ? 2'h0 : idx_r + 2'h1;
			if (state_r != S_CRC)
				crc_nxt = crc_calc;
			// checksum restarts for the next payload
			if (ol_nxt) begin
				last_crc_nxt = (state_r == S_CRC) ? crc_r : crc_calc;
				crc_nxt = `ICAPP_RST_CRC;
			end
		end
		// input waits while a byte or a chunk is pending
		ready_nxt = (state_nxt == S_PASS) && !ov_nxt;
	end

	// =====================================================================
	// stream registers
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= S_PASS;
			idx_r <= 2'h0;
			crc_r <= `ICAPP_RST_CRC;
			last_crc_r <= `ICAPP_RST_CRC;
			OUT_VALID <= 1'b0;
			OUT_DATA <= 8'h00;
			OUT_LAST <= 1'b0;
			IMG_READY <= 1'b0;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			crc_r <= crc_nxt;
			last_crc_r <= last_crc_nxt;
			OUT_VALID <= ov_nxt;
			OUT_DATA <= od_nxt;
			OUT_LAST <= ol_nxt;
			IMG_READY <= ready_nxt;
		end
	end
endmodule // icapp_top

//--- icapp_assertions.sv
// port checker for the image chunk appender
`timescale 1ns/1ps
`include "icapp_map.vh"
module icapp_chk #(
	parameter N_IN = 1,
	parameter N_OUT = 4,
	parameter SEQ_W = 8
) (
	// clock and reset
	input wire REF_CLK,
	input wire RSTN,
	// apb
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	input wire [31:0] PRDATA,
	input wire PREADY,
	input wire PSLVERR,
	// pins
	input wire TRIG,
	input wire [N_IN-1:0] IN_LINES,
	input wire [N_OUT-1:0] OUT_LINES,
	input wire SEQ_ACTIVE,
	input wire [SEQ_W-1:0] SEQ_INDEX,
	// streams
	input wire IMG_VALID,
	input wire [7:0] IMG_DATA,
	input wire IMG_LAST,
	input wire IMG_READY,
	input wire OUT_VALID,
	input wire [7:0] OUT_DATA,
	input wire OUT_LAST,
	input wire OUT_READY
);
	reg mode_r;
	wire rd_ok = PREADY && !PWRITE;
	// =====
	// chunk mode as last written
	always @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN)
			mode_r <= 1'b0;
		else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `ICAPP_OFF_CTRL)
			mode_r <= PWDATA[0];
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	apb_wait_a: assert property ($rose(PENABLE) && PSEL |=> PREADY) else $error("no ready in access");
	ready_one_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
	unmapped_err_a: assert property (PREADY && PADDR > `ICAPP_OFF_STAT |-> PSLVERR && (PWRITE || PRDATA == 0))
		else $error("unmapped not refused");
	gate_mode_a: assert property (rd_ok && PADDR == `ICAPP_OFF_STAT && !mode_r |-> PRDATA[2:0] == 0)
		else $error("enable without mode");
	snap_pad_a: assert property (rd_ok && PADDR == `ICAPP_OFF_LINES |-> PRDATA[31:N_IN+N_OUT] == 0)
		else $error("unmapped snapshot bits set");
	hold_out_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA) && $stable(OUT_LAST))
		else $error("output byte dropped");
	stall_in_a: assert property (OUT_VALID |-> !IMG_READY) else $error("input taken while full");
	pass_byte_a: assert property (IMG_VALID && IMG_READY |=> OUT_VALID && OUT_DATA == $past(IMG_DATA))
		else $error("image byte lost");
endmodule // icapp_chk

bind icapp_top icapp_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .SEQ_W(SEQ_W)) u_chk (
	.REF_CLK(REF_CLK), .RSTN(RSTN),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TRIG(TRIG), .IN_LINES(IN_LINES), .OUT_LINES(OUT_LINES), .SEQ_ACTIVE(SEQ_ACTIVE), .SEQ_INDEX(SEQ_INDEX),
	.IMG_VALID(IMG_VALID), .IMG_DATA(IMG_DATA), .IMG_LAST(IMG_LAST), .IMG_READY(IMG_READY),
	.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY)
);

//--- icapp_host.sv
// host model: takes each payload and checks its checksum
`timescale 1ns/1ps
module icapp_host (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// payload stream
	input wire valid,
	input wire [7:0] data,
	input wire last,
	output reg ready,
	// stall control
	input wire slow
);
	reg [7:0] mem [0:63];
	reg [15:0] calc;
	reg good;
	int cnt, len, nf;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
			cnt = 0;
			nf = 0;
		end else begin
			ready <= slow ? ~ready : 1'b1;
			if (valid && ready) begin
				mem[cnt] = data;
				cnt = cnt + 1;
				if (last) begin
					calc = 16'h0000;
					for (int i = 0; i < cnt - 2; i++) begin
						calc = calc ^ {mem[i], 8'h00};
						repeat (8) calc = calc[15] ? {calc[14:0], 1'b0} ^ 16'h1021 : {calc[14:0], 1'b0};
					end
					good = calc === {mem[cnt-2], mem[cnt-1]};
					len = cnt;
					cnt = 0;
					nf = nf + 1;
				end
			end
		end
	end
endmodule // icapp_host

//--- image_chunk_appender_tb_top.sv
// testbench for the image chunk appender
`timescale 1ns/1ps
`include "icapp_map.vh"
module image_chunk_appender_tb_top;
	reg REF_CLK, RSTN, PSEL, PENABLE, PWRITE, TRIG, SEQ_ACTIVE, IMG_VALID, IMG_LAST, in_l, slow, e;
	reg [7:0] PADDR, IMG_DATA, SEQ_INDEX;
	reg [31:0] PWDATA, r;
	reg [15:0] xcrc;
	reg [3:0] out_l;
	wire [31:0] PRDATA;
	wire [7:0] OUT_DATA;
	wire PREADY, PSLVERR, IMG_READY, OUT_VALID, OUT_LAST, OUT_READY;
	int n_fail, num_checks;
	reg [7:0] q[$];
	icapp_top dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG(TRIG),
		.IN_LINES(in_l), .OUT_LINES(out_l), .SEQ_ACTIVE(SEQ_ACTIVE), .SEQ_INDEX(SEQ_INDEX),
		.IMG_VALID(IMG_VALID), .IMG_DATA(IMG_DATA), .IMG_LAST(IMG_LAST), .IMG_READY(IMG_READY),
		.OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .OUT_LAST(OUT_LAST), .OUT_READY(OUT_READY));
	icapp_host host (.clk(REF_CLK), .rst_n(RSTN), .valid(OUT_VALID), .data(OUT_DATA), .last(OUT_LAST),
		.ready(OUT_READY), .slow(slow));
	initial begin
		REF_CLK = 0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	task give_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input [31:0] g, input [31:0] x);
		num_checks++;
		if (g !== x) begin
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
			n_fail++;
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		@(posedge REF_CLK);
		PSEL <= 1; PENABLE <= 0; PWRITE <= w; PADDR <= a; PWDATA <= d;
		@(posedge REF_CLK);
		PENABLE <= 1;
		do @(posedge REF_CLK); while (PREADY !== 1'b1);
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 0; PENABLE <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] x);
		apb(0, a, 0);
		chk(r, x);
	endtask
	task p32(input [31:0] v);
		for (int j = 24; j >= 0; j -= 8) q.push_back(v[j+:8]);
	endtask
	// =====
	// one frame: trigger, image bytes, expected chunks
	task frame(input int n, input [2:0] en);
		int k, w;
		k = host.nf;
		q.delete();
		TRIG <= 1;
		repeat (2) @(posedge REF_CLK);
		TRIG <= 0;
		repeat (4) @(posedge REF_CLK);
		for (int i = 0; i < n; i++) begin
			q.push_back(8'h30 + i[7:0]);
			IMG_VALID <= 1; IMG_DATA <= 8'h30 + i[7:0]; IMG_LAST <= (i == n - 1);
			do @(posedge REF_CLK); while (IMG_READY !== 1'b1);
		end
		IMG_VALID <= 0;
		if (en[0]) p32({27'h0, out_l, in_l});
		if (en[2]) p32({24'h0, SEQ_INDEX});
		xcrc = 16'h0000;
		foreach (q[i]) begin
			xcrc = xcrc ^ {q[i], 8'h00};
			repeat (8) xcrc = xcrc[15] ? {xcrc[14:0], 1'b0} ^ `ICAPP_CRC_POLY : {xcrc[14:0], 1'b0};
		end
		for (w = 0; w < 400 && host.nf == k; w++) @(posedge REF_CLK);
		chk(host.len, q.size() + 2 * en[1]);
		foreach (q[i]) chk(host.mem[i], q[i]);
		if (en[1]) chk(host.good, 1);
		if (en[1]) chk({host.mem[q.size()], host.mem[q.size() + 1]}, xcrc);
	endtask
	initial begin
		repeat (30000) @(posedge REF_CLK);
		n_fail++;
		give_verdict;
	end
	initial begin
		{RSTN, PSEL, PENABLE, PWRITE, TRIG, SEQ_ACTIVE, IMG_VALID, IMG_LAST, slow} = 0;
		PADDR = 0; PWDATA = 0; IMG_DATA = 0; SEQ_INDEX = 8'h5a; in_l = 1; out_l = 4'ha;
		n_fail = 0; num_checks = 0;
		repeat (12) @(posedge REF_CLK);
		RSTN <= 1;
		rd(`ICAPP_OFF_STAT, 0);
		apb(0, 8'h40, 0);
		chk(e, 1);
		apb(1, `ICAPP_OFF_SEL, 0);
		apb(1, `ICAPP_OFF_EN, 1);
		rd(`ICAPP_OFF_STAT, 0);
		apb(1, `ICAPP_OFF_CTRL, 1);
		apb(1, `ICAPP_OFF_SEL, 2);
		apb(1, `ICAPP_OFF_EN, 1);
		rd(`ICAPP_OFF_STAT, 0);
		SEQ_ACTIVE <= 1;
		for (int s = 0; s < 3; s++) begin
			apb(1, `ICAPP_OFF_SEL, s);
			apb(1, `ICAPP_OFF_EN, 1);
		end
		rd(`ICAPP_OFF_STAT, 7);
		rd(`ICAPP_OFF_EN, 1);
		rd(`ICAPP_OFF_CTRL, 3);
		slow <= 1;
		frame(5, 7);
		rd(`ICAPP_OFF_LINES, 32'h15);
		rd(`ICAPP_OFF_CRC, xcrc);
		apb(1, `ICAPP_OFF_CTRL, 0);
		rd(`ICAPP_OFF_STAT, 0);
		in_l <= 0; out_l <= 4'h5; slow <= 0;
		frame(4, 0);
		rd(`ICAPP_OFF_CRC, xcrc);
		apb(1, `ICAPP_OFF_CTRL, 1);
		apb(1, `ICAPP_OFF_SEL, 1);
		apb(1, `ICAPP_OFF_EN, 1);
		frame(3, 2);
		rd(`ICAPP_OFF_LINES, 32'h0a);
		apb(1, `ICAPP_OFF_EN, 0);
		rd(`ICAPP_OFF_STAT, 0);
		apb(1, `ICAPP_OFF_SEL, 3);
		apb(1, `ICAPP_OFF_EN, 1);
		rd(`ICAPP_OFF_STAT, 0);
		rd(`ICAPP_OFF_EN, 0);
		give_verdict;
	end
endmodule // image_chunk_appender_tb_top
